// File: design/pas_pkg.sv
// constants and types shared by the pattern address sequencer
package pas_pkg;
    localparam int PAS_ADDR_W_MAX  = 14;       // 0..16383 on the large variant
    localparam int PAS_ADDR_W_SML  = 10;       // 0..1023 on the small variant
    localparam int PAS_DATA_W      = 16;
    localparam int PAS_FIFO_DEPTH  = 16;
    localparam int PAS_CLK_MHZ     = 10;       // mclk rate
    localparam int PAS_MAX_SEQ_MHZ = 50;       // highest sequencing rate
    localparam logic [2:0] PAS_MODE_AUTO   = 3'h0;
    localparam logic [2:0] PAS_MODE_SINGLE = 3'h1;
    localparam logic [2:0] PAS_MODE_GATED  = 3'h2;
    localparam logic [2:0] PAS_MODE_INITG  = 3'h3;
    localparam logic [2:0] PAS_MODE_INITA  = 3'h4;
    localparam logic [3:0] PAS_OFS_CTRL    = 4'h0;  // mode, strobe ctl
    localparam logic [3:0] PAS_OFS_FIRST   = 4'h1;
    localparam logic [3:0] PAS_OFS_LAST    = 4'h2;
    localparam logic [3:0] PAS_OFS_CMD     = 4'h3;  // command keys
    localparam logic [3:0] PAS_OFS_STATUS  = 4'h4;
    localparam logic [3:0] PAS_OFS_ADDR    = 4'h5;
    localparam int PAS_CMD_RUN   = 0;
    localparam int PAS_CMD_STOP  = 1;
    localparam int PAS_CMD_BREAK = 2;
    localparam int PAS_CMD_FWD   = 3;
    localparam int PAS_CMD_BACK  = 4;
    localparam int PAS_CTL_SBRK  = 3;   // strobe breaks enable bit
    localparam int PAS_CTL_SCLK  = 4;   // strobe output carries clock
    localparam int PAS_CTL_RUNEN = 5;   // run/gate input enabled
    typedef enum logic [1:0] {
        PAS_ST_STOP,
        PAS_ST_RUN,
        PAS_ST_BREAK
    } pas_state_e;
endpackage

// File: design/pas_fifo.sv
// small synchronous fifo between the sequencer and the pattern output
`timescale 1ns/1ns
`default_nettype none
module pas_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("pas_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    wire              full  = (wp_r[AW] != rp_r[AW]) &&
                            (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire              empty = (wp_r == rp_r);
    wire              push  = in_valid && !full;
    wire              pop   = out_ready && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp_r[AW-1:0]];
    // storage has no reset; pointers guard it
    always_ff @(posedge clk) begin
        if (push)
            mem[wp_r[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_r + (AW+1)'(push);
            rp_r <= rp_r + (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// File: design/pas_seq.sv
// pattern address sequencer with command port, pattern memory and fifo
`timescale 1ns/1ns
`default_nettype none
module pas_seq
    import pas_pkg::*;
#(
    parameter int ADDR_W = PAS_ADDR_W_MAX,
    parameter int DATA_W = PAS_DATA_W,
    parameter int DEPTH  = PAS_FIFO_DEPTH
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    input  wire logic              run_gate_in,
    input  wire logic              mem_wr,
    input  wire logic [ADDR_W-1:0] mem_waddr,
    input  wire logic [DATA_W:0]   mem_wdata,
    output logic [DATA_W-1:0]      dut_data,
    output logic                   dut_strobe,
    output logic                   dut_valid,
    input  wire logic              dut_ready,
    output logic [ADDR_W-1:0]      cur_addr
);
    initial begin
        if (ADDR_W != PAS_ADDR_W_MAX && ADDR_W != PAS_ADDR_W_SML)
            $error("pas_seq address width must be 14 or 10");
    end
    localparam logic [ADDR_W-1:0] A_ZERO = '0;
    localparam logic [ADDR_W-1:0] A_ONE  = ADDR_W'(1);

    // pattern memory: data word plus strobe bit on top
    logic [DATA_W:0] pmem [1 << ADDR_W];

    // registers
    logic [2:0]        mode_r;
    logic              sbrk_en_r;
    logic              sclk_sel_r;
    logic              run_en_r;
    logic [ADDR_W-1:0] first_r;
    logic [ADDR_W-1:0] last_r;
    logic [4:0]        cmd_r;
    pas_state_e        st_r;
    pas_state_e        st_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [ADDR_W-1:0] diff_r;     // addresses left in this cycle
    logic [ADDR_W-1:0] diff_nxt;
    logic              init_r;     // init pass from zero pending
    logic              init_nxt;
    logic              finish_r;   // gate dropped, finish the cycle
    logic              finish_nxt;
    logic              gate_s1_r;
    logic              gate_s2_r;
    logic              gate_d_r;
    logic              tick_r;
    logic [31:0]       rdata_r;

    // gate pin passes two flops; the first flop feeds only the second
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gate_s1_r <= 1'b0;
            gate_s2_r <= 1'b0;
            gate_d_r  <= 1'b0;
        end else begin
            gate_s1_r <= run_gate_in;
            gate_s2_r <= gate_s1_r;
            gate_d_r  <= gate_s2_r;
        end
    end

    // command decode; key writes are taken one cycle later, same clock
    wire wr_ctrl  = reg_wr && reg_addr == PAS_OFS_CTRL;
    wire wr_first = reg_wr && reg_addr == PAS_OFS_FIRST;
    wire wr_last  = reg_wr && reg_addr == PAS_OFS_LAST;
    wire wr_cmd   = reg_wr && reg_addr == PAS_OFS_CMD;
    wire c_run    = cmd_r[PAS_CMD_RUN];
    wire c_stop   = cmd_r[PAS_CMD_STOP];
    wire c_break  = cmd_r[PAS_CMD_BREAK];
    wire c_fwd    = cmd_r[PAS_CMD_FWD];
    wire c_back   = cmd_r[PAS_CMD_BACK];
    wire gated    = mode_r == PAS_MODE_GATED || mode_r == PAS_MODE_INITG;
    wire is_init  = mode_r == PAS_MODE_INITG || mode_r == PAS_MODE_INITA;
    wire gate_on  = gate_s2_r && !gate_d_r && run_en_r;
    wire gate_off = !gate_s2_r && gate_d_r;
    wire at_end   = diff_r == A_ZERO;
    wire [ADDR_W-1:0] span  = last_r - first_r;
    logic             fifo_ready;
    wire              strb  = pmem[addr_r][DATA_W];
    // step only when the fifo takes the word now; a registered ready
    // would let one step through on the edge the fifo fills
    wire              adv   = st_r == PAS_ST_RUN && fifo_ready;
    wire [ADDR_W-1:0] wrap_a = is_init ? A_ZERO : first_r;
    wire [ADDR_W-1:0] wrap_d = is_init ? last_r : span;

    // sequencing clock phase for the strobe output, follows the fifo
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            tick_r <= 1'b0;
        else
            tick_r <= fifo_ready;
    end

    // next-state logic of the sequencer
    always_comb begin
        st_nxt     = st_r;
        addr_nxt   = addr_r;
        diff_nxt   = diff_r;
        init_nxt   = init_r;
        finish_nxt = finish_r;
        unique case (st_r)
            PAS_ST_STOP: begin
                // start from first, or from zero in init modes
                if ((c_run && !gated) || (gated && gate_on)) begin
                    st_nxt     = PAS_ST_RUN;
                    addr_nxt   = wrap_a;
                    diff_nxt   = wrap_d;
                    init_nxt   = is_init;
                    finish_nxt = 1'b0;
                end
            end
            PAS_ST_RUN: begin
                if (c_stop) begin
                    st_nxt = PAS_ST_STOP;
                end else if (c_break) begin
                    st_nxt = PAS_ST_BREAK;
                end else if (sbrk_en_r && strb) begin
                    st_nxt = PAS_ST_BREAK;
                end else if (adv) begin
                    if (gated && gate_off)
                        finish_nxt = 1'b1;
                    if (!at_end) begin
                        addr_nxt = addr_r + A_ONE;
                        diff_nxt = diff_r - A_ONE;
                    end else if (mode_r == PAS_MODE_SINGLE ||
                                 (gated && (finish_r || !gate_s2_r))) begin
                        st_nxt = PAS_ST_STOP;
                    end else begin
                        addr_nxt = first_r;
                        diff_nxt = span;
                        init_nxt = 1'b0;
                    end
                end
            end
            PAS_ST_BREAK: begin
                if (c_stop) begin
                    st_nxt = PAS_ST_STOP;
                end else if (c_fwd && addr_r != last_r) begin
                    addr_nxt = addr_r + A_ONE;
                    diff_nxt = diff_r - A_ONE;
                end else if (c_back && addr_r != first_r) begin
                    addr_nxt = addr_r - A_ONE;
                    diff_nxt = diff_r + A_ONE;
                end else if (c_run) begin
                    st_nxt   = PAS_ST_RUN;
                    if (at_end) begin
                        addr_nxt = first_r;
                        diff_nxt = span;
                    end else begin
                        addr_nxt = addr_r + A_ONE;
                        diff_nxt = diff_r - A_ONE;
                    end
                end
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r     <= PAS_ST_STOP;
            addr_r   <= '0;
            diff_r   <= '0;
            init_r   <= 1'b0;
            finish_r <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            addr_r   <= addr_nxt;
            diff_r   <= diff_nxt;
            init_r   <= init_nxt;
            finish_r <= finish_nxt;
        end
    end

    // register writes; widths clip to the address range
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_r     <= PAS_MODE_AUTO;
            sbrk_en_r  <= 1'b0;
            sclk_sel_r <= 1'b0;
            run_en_r   <= 1'b0;
            first_r    <= '0;
            last_r     <= '0;
            cmd_r      <= '0;
        end else begin
            cmd_r <= wr_cmd ? reg_wdata[4:0] : 5'h00;
            if (wr_ctrl) begin
                mode_r     <= reg_wdata[2:0];
                sbrk_en_r  <= reg_wdata[PAS_CTL_SBRK];
                sclk_sel_r <= reg_wdata[PAS_CTL_SCLK];
                run_en_r   <= reg_wdata[PAS_CTL_RUNEN];
            end
            if (wr_first)
                first_r <= reg_wdata[ADDR_W-1:0];
            if (wr_last)
                last_r <= reg_wdata[ADDR_W-1:0];
        end
    end

    // pattern memory load port
    always_ff @(posedge mclk) begin
        if (mem_wr)
            pmem[mem_waddr] <= mem_wdata;
    end

    // read mux; unmapped offsets read zero
    wire [31:0] rd_mux =
        reg_addr == PAS_OFS_CTRL   ? {26'h0, run_en_r, sclk_sel_r,
                                      sbrk_en_r, mode_r} :
        reg_addr == PAS_OFS_FIRST  ? 32'(first_r) :
        reg_addr == PAS_OFS_LAST   ? 32'(last_r) :
        reg_addr == PAS_OFS_STATUS ? {29'h0, gate_s2_r, 2'(st_r)} :
        reg_addr == PAS_OFS_ADDR   ? 32'(addr_r) : 32'h0;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            rdata_r <= '0;
        else if (reg_rd)
            rdata_r <= rd_mux;
    end
    assign reg_rdata = rdata_r;

    // words issued only while stepping in run state
    logic [DATA_W-1:0] f_data;
    logic              f_valid;
    logic [DATA_W-1:0] f_out;
    logic              f_strb_r;
    logic [DATA_W-1:0] dout_r;
    logic              dval_r;
    logic [ADDR_W-1:0] caddr_r;
    logic              f_out_valid;
    // output stage takes a new word when empty or when the sink drains it
    wire               f_take = !dval_r || dut_ready;
    assign f_data = pmem[addr_r][DATA_W-1:0];
    assign f_valid = adv;
    pas_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
        .clk       (mclk),
        .rst_n     (rstn),
        .in_valid  (f_valid),
        .in_ready  (fifo_ready),
        .in_data   (f_data),
        .out_valid (f_out_valid),
        .out_ready (f_take),
        .out_data  (f_out)
    );

    // output flops; reloading the data stage on every edge would drop a
    // word whenever the sink stalls; strobe is clock phase or strobe bit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dout_r   <= '0;
            dval_r   <= 1'b0;
            f_strb_r <= 1'b0;
            caddr_r  <= '0;
        end else begin
            if (f_take) begin
                dout_r <= f_out;
                dval_r <= f_out_valid;
            end
            f_strb_r  <= sclk_sel_r ? tick_r & ~f_strb_r : strb;
            caddr_r   <= addr_r;
        end
    end
    assign dut_data   = dout_r;
    assign dut_valid  = dval_r;
    assign dut_strobe = f_strb_r;
    assign cur_addr   = caddr_r;

    // assertions
    property p_break_hold;
        @(posedge mclk) disable iff (!rstn)
        (st_r == PAS_ST_BREAK && cmd_r == 5'h00) |=> $stable(addr_r);
    endproperty
    a_break_hold: assert property (p_break_hold)
        else $error("address moved in break");
    property p_back_floor;
        @(posedge mclk) disable iff (!rstn)
        (st_r == PAS_ST_BREAK) |-> (addr_r >= first_r || is_init);
    endproperty
    a_back_floor: assert property (p_back_floor)
        else $error("address below first in break");
    property p_stop_run;
        @(posedge mclk) disable iff (!rstn)
        (st_r == PAS_ST_STOP && c_run && !gated) |=>
            (st_r == PAS_ST_RUN && addr_r == (is_init ? A_ZERO : first_r));
    endproperty
    a_stop_run: assert property (p_stop_run)
        else $error("run from stop not at first address");
    property p_single_stop;
        @(posedge mclk) disable iff (!rstn)
        (mode_r == PAS_MODE_SINGLE && adv && at_end && cmd_r == 5'h00
         && !(sbrk_en_r && strb)) |=> st_r == PAS_ST_STOP;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single cycle did not stop at last");
    property p_wrap;
        @(posedge mclk) disable iff (!rstn)
        (mode_r == PAS_MODE_AUTO && adv && at_end && cmd_r == 5'h00
         && !(sbrk_en_r && strb)) |=> addr_r == $past(first_r);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("auto mode did not wrap to first");
    property p_resume;
        @(posedge mclk) disable iff (!rstn)
        (st_r == PAS_ST_BREAK && cmd_r == 5'h01 && !at_end) |=>
            addr_r == $past(addr_r) + A_ONE;
    endproperty
    a_resume: assert property (p_resume)
        else $error("run from break not at next address");
    property p_strobe_brk;
        @(posedge mclk) disable iff (!rstn)
        (st_r == PAS_ST_RUN && sbrk_en_r && strb &&
         cmd_r == 5'h00) |=> (st_r == PAS_ST_BREAK && $stable(addr_r));
    endproperty
    a_strobe_brk: assert property (p_strobe_brk)
        else $error("strobe break missed");
    property p_gate_sync;
        @(posedge mclk) disable iff (!rstn)
        $rose(gate_s2_r) |-> $past(gate_s1_r);
    endproperty
    a_gate_sync: assert property (p_gate_sync)
        else $error("gate bypassed synchroniser");
endmodule
`default_nettype wire

// File: bench/pas_sink.sv
// model of the circuit under test that takes the generated pattern words
`timescale 1ns/1ns
`default_nettype none
module pas_sink (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        dut_valid,
    input  wire logic [15:0] dut_data,
    output logic             dut_ready
);
    int          seed = 32'h9B2F;
    logic [15:0] got_q[$];

    // take a word at each edge where valid meets ready; stall at random
    // when slow, so the fifo really fills and the sequencer must wait
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dut_ready <= 1'b0;
        end else begin
            if (dut_valid && dut_ready) got_q.push_back(dut_data);
            dut_ready <= slow ? (($random(seed) & 1) != 0) : 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: bench/pas_seq_tb.sv
// self-checking bench of the pattern address sequencer
`timescale 1ns/1ns
`default_nettype none
module pas_seq_tb;
    import pas_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        run_gate_in = 1'b0;
    logic        mem_wr = 1'b0;
    logic [13:0] mem_waddr = 14'h0;
    logic [16:0] mem_wdata = 17'h0;
    logic [15:0] dut_data;
    logic        dut_strobe;
    logic        dut_valid;
    logic        dut_ready;
    logic [13:0] cur_addr;
    logic        slow = 1'b1;
    int          errors = 0;
    int          checks = 0;
    int          seed = 32'h9B2F;
    int          cyc = 0;
    logic [15:0] mem_m [128];
    logic [15:0] exp_q[$];
    logic [31:0] rd_v;

    pas_seq i_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .run_gate_in(run_gate_in), .mem_wr(mem_wr),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .dut_data(dut_data),
        .dut_strobe(dut_strobe), .dut_valid(dut_valid),
        .dut_ready(dut_ready), .cur_addr(cur_addr));
    pas_sink i_sink (.mclk(mclk), .rstn(rstn), .slow(slow),
        .dut_valid(dut_valid), .dut_data(dut_data), .dut_ready(dut_ready));

    // clock and hang guard; the whole run needs well under 40000 cycles
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // received words against the model stream; exact also checks the count
    task automatic chk_seq(input bit exact);
        foreach (i_sink.got_q[i]) chk(i_sink.got_q[i], exp_q[i]);
        if (exact) chk(i_sink.got_q.size(), exp_q.size());
        i_sink.got_q.delete();
    endtask

    // model address walk: start, then first..last over and over
    task automatic build(input int start, input int first, input int last,
                         input int n);
        int a;
        a = start;
        exp_q.delete();
        repeat (n) begin
            exp_q.push_back(mem_m[a]);
            a = (a == last) ? first : a + 1;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // read data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rd_v = reg_rdata;
    endtask

    task automatic cmd(input int b);
        wr(PAS_OFS_CMD, 32'h1 << b);
    endtask

    // poll the state field, then let the fifo drain into the sink
    task automatic wait_state(input logic [1:0] st);
        int n;
        repeat (8) @(posedge mclk);
        for (n = 0; n < 3000; n++) begin
            rd(PAS_OFS_STATUS);
            if (rd_v[1:0] === st) break;
        end
        chk(rd_v[1:0], st);
        repeat (80) @(posedge mclk);
    endtask

    task automatic gated(input int f, input logic [31:0] mode);
        wr(PAS_OFS_FIRST, f);
        wr(PAS_OFS_CTRL, mode | 32'h20);
        @(posedge mclk) run_gate_in <= 1'b1;
        repeat (200) @(posedge mclk);
        run_gate_in <= 1'b0;
        wait_state(2'h0);
        chk(i_sink.got_q[$], mem_m[10]);
        chk(cur_addr, 10);
        build(0, f, 10, 800);
        chk_seq(0);
    endtask

    initial begin
        int b;
        int f;
        int t;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        // pattern load: random words, strobe bit at 0 and powers of two
        for (int i = 0; i < 128; i++) begin
            mem_m[i] = $random(seed);
            @(posedge mclk);
            mem_wr <= 1'b1;
            mem_waddr <= i;
            mem_wdata <= {(i & (i - 1)) == 0, mem_m[i]};
        end
        @(posedge mclk) mem_wr <= 1'b0;
        wr(PAS_OFS_CTRL, 32'h21);
        rd(PAS_OFS_CTRL);
        chk(rd_v, 32'h21);
        wr(4'hF, 32'hFFFF);
        rd(4'hF);
        chk(rd_v, 32'h0);
        // auto mode, break, steps, resume
        wr(PAS_OFS_FIRST, 0);
        wr(PAS_OFS_LAST, 10);
        rd(PAS_OFS_LAST);
        chk(rd_v, 32'hA);
        wr(PAS_OFS_CTRL, 32'h0);
        cmd(PAS_CMD_RUN);
        repeat (150) @(posedge mclk);
        cmd(PAS_CMD_BREAK);
        wait_state(2'h2);
        build(0, 0, 10, 800);
        chk_seq(0);
        b = cur_addr;
        repeat (60) @(posedge mclk);
        chk(cur_addr, b);
        chk(i_sink.got_q.size(), 0);
        f = (b < 10) ? b + 1 : b;
        cmd(PAS_CMD_FWD);
        repeat (10) @(posedge mclk);
        chk(cur_addr, f);
        cmd(PAS_CMD_BACK);
        repeat (10) @(posedge mclk);
        chk(cur_addr, f - 1);
        cmd(PAS_CMD_FWD);
        repeat (10) @(posedge mclk);
        i_sink.got_q.delete();
        cmd(PAS_CMD_RUN);
        repeat (100) @(posedge mclk);
        cmd(PAS_CMD_BREAK);
        wait_state(2'h2);
        build((f == 10) ? 0 : f + 1, 0, 10, 800);
        chk_seq(0);
        // stop, new first address, run again from it
        cmd(PAS_CMD_STOP);
        wait_state(2'h0);
        wr(PAS_OFS_FIRST, 2);
        i_sink.got_q.delete();
        cmd(PAS_CMD_RUN);
        repeat (100) @(posedge mclk);
        cmd(PAS_CMD_STOP);
        wait_state(2'h0);
        build(2, 2, 10, 800);
        chk_seq(0);
        // single passes over several cycle lengths
        wr(PAS_OFS_FIRST, 0);
        wr(PAS_OFS_CTRL, 32'h1);
        for (int k = 0; k < 5; k++) begin
            t = (k < 2) ? k + 1 : 8 << (k - 2);
            wr(PAS_OFS_LAST, t);
            cmd(PAS_CMD_RUN);
            wait_state(2'h0);
            build(0, 0, t, t + 1);
            chk_seq(1);
            chk(cur_addr, t);
        end
        // gated and init plus gated, gate taken through the synchroniser
        wr(PAS_OFS_LAST, 10);
        gated(0, PAS_MODE_GATED);
        gated(3, PAS_MODE_INITG);
        // init plus auto with the run input switched off
        wr(PAS_OFS_CTRL, PAS_MODE_INITA);
        cmd(PAS_CMD_RUN);
        repeat (150) @(posedge mclk);
        cmd(PAS_CMD_STOP);
        wait_state(2'h0);
        build(0, 3, 10, 800);
        chk_seq(0);
        // strobe breaks step from flag to flag and wrap to the lowest
        wr(PAS_OFS_FIRST, 0);
        wr(PAS_OFS_LAST, 127);
        wr(PAS_OFS_CTRL, 32'h08);
        cmd(PAS_CMD_RUN);
        wait_state(2'h2);
        chk(cur_addr, 0);
        cmd(PAS_CMD_BACK);
        repeat (10) @(posedge mclk);
        chk(cur_addr, 0);
        for (int k = 0; k < 8; k++) begin
            cmd(PAS_CMD_RUN);
            wait_state(2'h2);
            chk(cur_addr, (k < 7) ? (1 << k) : 0);
        end
        cmd(PAS_CMD_STOP);
        wait_state(2'h0);
        // strobe output as clock must keep toggling while running
        wr(PAS_OFS_CTRL, 32'h10);
        cmd(PAS_CMD_RUN);
        repeat (20) @(posedge mclk);
        #1;
        t = 0;
        repeat (40) begin
            b = dut_strobe;
            @(posedge mclk);
            #1 if (dut_strobe !== b[0]) t++;
        end
        chk(t > 4, 1);
        cmd(PAS_CMD_STOP);
        wait_state(2'h0);
        stop_test();
    end
endmodule
`default_nettype wire
